// [ebs_mem_model.sv]
/* Far-side model: low address latch, code memory and data memory.
   Assumes the strobe and port 0 pins of ebs_strobes on one clock. */
`timescale 1ns/100ps
`default_nettype none
module ebs_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic        ale_i,
    input  wire logic        fetch_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [7:0]  high_i,
    input  wire logic [7:0]  bus_i,
    input  wire logic        bus_oe_i,
    output logic      [7:0]  bus_o,
    output logic      [15:0] last_addr_o
);
    logic [7:0] low = 8'h00;
    logic [7:0] prev = 8'h00;
    logic [7:0] mem [256];
    always_comb begin
        if (bus_oe_i) begin
            bus_o = bus_i;
        end else if (!fetch_n_i) begin
            bus_o = low ^ high_i ^ 8'h5a;
        end else if (!rd_n_i) begin
            bus_o = mem[low ^ high_i];
        end else begin
            // released bus never repeats the last value
            bus_o = ~prev;
        end
    end
    always @(posedge clk_sys_i) begin
        prev <= bus_o;
        if (ale_i) low <= bus_o;
        if (!wr_n_i) mem[low ^ high_i] <= bus_o;
        if (!wr_n_i || !rd_n_i) last_addr_o <= {high_i, low};
    end
endmodule : ebs_mem_model
`default_nettype wire

// [ebs_pkg.sv]
/*
 * Constants and carrier types for the external bus strobe block.
 * Assumes one oscillator clock that also clocks the strobe sequencer.
 */
package ebs_pkg;
    // register map
    localparam logic [7:0] AUX_ADDR    = 8'h8e;
    localparam logic [7:0] CLK_ADDR    = 8'h8f;
    localparam logic [7:0] AUX_RESET   = 8'h00;
    localparam logic [7:0] CLK_RESET   = 8'h00;
    localparam logic [7:0] AUX_MASK    = 8'h2f;
    localparam logic [7:0] CLK_MASK    = 8'h7f;
    localparam int         AUX_ALE_OFF = 0;
    localparam int         CLK_X2      = 0;

    // timing
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         OSC_PER_MC_STD = 12;
    localparam int         OSC_PER_MC_X2  = 6;
    localparam int         RST_HOLD_MC    = 2;
    localparam logic [2:0] SLOT_LEN_STD   = 3'(OSC_PER_MC_STD / 2);
    localparam logic [2:0] SLOT_LEN_X2    = 3'(OSC_PER_MC_X2 / 2);
    localparam logic [2:0] ALE_LEN_STD    = 3'd2;
    localparam logic [2:0] ALE_LEN_X2     = 3'd1;
    localparam logic [4:0] RST_HOLD_STD   = 5'(RST_HOLD_MC * OSC_PER_MC_STD);
    localparam logic [4:0] RST_HOLD_X2    = 5'(RST_HOLD_MC * OSC_PER_MC_X2);

    typedef enum {
        SLOT_CODE,
        SLOT_XDATA_A,
        SLOT_XDATA_B
    } ebs_slot_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        short_addr;
    } ebs_xreq_t;

    typedef struct packed {
        logic ale;
        logic fetch_n;
        logic rd_n;
        logic wr_n;
    } ebs_strobes_t;

    function automatic logic [2:0] ebs_slot_len(input logic x2);
        return x2 ? SLOT_LEN_X2 : SLOT_LEN_STD;
    endfunction : ebs_slot_len

    function automatic logic [2:0] ebs_ale_len(input logic x2);
        return x2 ? ALE_LEN_X2 : ALE_LEN_STD;
    endfunction : ebs_ale_len
endpackage : ebs_pkg

// [ebs_strobes.sv]
/*
 * External bus strobe generator: address latch pulse, program fetch
 * strobe, data read/write strobes, port 0/high address drive, reset pin
 * and external code select handling, two control registers.
 * Assumes clk_sys_i is the oscillator and the core presents fetch and
 * data move requests in the same clock domain.
 */
// Notes on behaviour
// - a reset pin held high for two machine cycles gives a full reset.
// - a watchdog reset drives the reset pin as an output.
// - the latch strobe pulses at osc/6, or osc/3 in double speed.
// - each external data move drops one latch strobe pulse, or adds one while the disable bit mutes internal fetches.
// - with the latch-strobe disable bit set, no pulse on internal fetches.
// - the latch strobe marks the low address byte valid on port 0.
// - executing externally, the fetch strobe fires twice per machine cycle.
// - each external data move suppresses two consecutive fetch strobes.
// - the fetch strobe never fires on internal fetches.
// - with security level 1 the code select pin is latched at reset.
// - a dedicated low strobe marks each external data write.
// - a dedicated low strobe marks each external data read.
// - high address port carries the high byte, or its latch on 8-bit moves.
// - the double speed bit selects 12 or 6 clocks per machine cycle.
`timescale 1ns/100ps
`default_nettype none
module ebs_strobes (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // register port
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_write_i,
    input  wire logic              reg_read_i,
    output logic      [7:0]        reg_rdata_o,
    // core side
    input  wire logic              fetch_external_i,
    input  wire logic [15:0]       fetch_addr_i,
    output logic      [7:0]        fetch_data_o,
    output logic                   fetch_data_valid_o,
    input  wire logic              xreq_valid_i,
    input  wire ebs_pkg::ebs_xreq_t xreq_i,
    output logic                   xreq_ready_o,
    output logic      [7:0]        xdata_rdata_o,
    output logic                   xdata_done_o,
    input  wire logic [7:0]        high_address_latch_i,
    input  wire logic              watchdog_reset_i,
    input  wire logic              security_level1_i,
    output logic                   sys_reset_o,
    output logic                   code_external_o,
    output logic                   double_speed_o,
    // pins
    output logic                   ale_o,
    output logic                   program_fetch_strobe_n_o,
    output logic                   rd_n_o,
    output logic                   wr_n_o,
    output logic      [7:0]        high_address_port_o,
    input  wire logic [7:0]        port0_i,
    output logic      [7:0]        port0_o,
    output logic                   port0_oe_o,
    input  wire logic              rst_pin_i,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe_o,
    input  wire logic              external_code_select_i
);
    import ebs_pkg::*;

    logic         rst_pin_s;
    logic         code_sel_s;
    logic [7:0]   port0_s;
    logic [4:0]   rst_cnt;
    logic         pin_reset;
    logic         code_sel_held;
    logic         sys_reset_d;
    logic [7:0]   auxiliary_control;
    logic [7:0]   clock_speed_control;
    logic         x2_active;
    logic [2:0]   phase;
    logic [2:0]   slot_len;
    logic [2:0]   ale_len;
    logic         slot_end;
    logic         mc_end;
    logic         slot_idx;
    ebs_slot_t    slot;
    ebs_slot_t    next_slot;
    ebs_xreq_t    xreq_q;
    logic         xreq_pend;
    ebs_strobes_t next_strb;
    logic         ale_allowed;

    ebs_sync #(.W(2), .INIT(2'b01)) u_sync_pins (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   ({rst_pin_i, external_code_select_i}),
        .sync_o    ({rst_pin_s, code_sel_s})
    );

    ebs_sync #(.W(8), .INIT(8'hff)) u_sync_port0 (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   (port0_i),
        .sync_o    (port0_s)
    );

    // reset pin filter: full reset once held two machine cycles
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rst_cnt   <= 5'h00;
            pin_reset <= 1'b0;
        end else if (!rst_pin_s || rst_pin_oe_o) begin
            rst_cnt   <= 5'h00;
            pin_reset <= 1'b0;
        end else if (rst_cnt >= (x2_active ? RST_HOLD_X2 : RST_HOLD_STD)) begin
            pin_reset <= 1'b1;
        end else begin
            rst_cnt   <= rst_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sys_reset_o  <= 1'b1;
            sys_reset_d  <= 1'b1;
            rst_pin_oe_o <= 1'b0;
        end else begin
            sys_reset_o  <= pin_reset || watchdog_reset_i;
            sys_reset_d  <= sys_reset_o;
            rst_pin_oe_o <= watchdog_reset_i;
        end
    end

    assign rst_pin_o = 1'b1;

    // code select capture at reset release
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            code_sel_held <= 1'b1;
        end else if (sys_reset_d && !sys_reset_o) begin
            code_sel_held <= code_sel_s;
        end
    end

    // low on the select pin permits external code
    assign code_external_o = security_level1_i ? !code_sel_held : !code_sel_s;

    // control registers
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            auxiliary_control   <= AUX_RESET;
            clock_speed_control <= CLK_RESET;
        end else if (sys_reset_o) begin
            auxiliary_control   <= AUX_RESET;
            clock_speed_control <= CLK_RESET;
        end else if (reg_write_i) begin
            if (reg_addr_i == AUX_ADDR) begin
                auxiliary_control <= reg_wdata_i & AUX_MASK;
            end
            if (reg_addr_i == CLK_ADDR) begin
                clock_speed_control <= reg_wdata_i & CLK_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                AUX_ADDR: reg_rdata_o <= auxiliary_control;
                CLK_ADDR: reg_rdata_o <= {clock_speed_control[7:1], x2_active};
                default:  reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // machine cycle timebase; speed change only at cycle boundary
    assign slot_len = ebs_slot_len(x2_active);
    assign ale_len  = ebs_ale_len(x2_active);
    assign slot_end = (phase == slot_len - 3'd1);
    assign mc_end   = slot_end && slot_idx;
    assign double_speed_o = x2_active;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            x2_active <= 1'b0;
        end else if (sys_reset_o) begin
            x2_active <= 1'b0;
        end else if (mc_end) begin
            x2_active <= clock_speed_control[CLK_X2];
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            phase    <= 3'd0;
            slot_idx <= 1'b0;
        end else if (sys_reset_o) begin
            phase    <= 3'd0;
            slot_idx <= 1'b0;
        end else if (slot_end) begin
            phase    <= 3'd0;
            slot_idx <= !slot_idx;
        end else begin
            phase    <= phase + 3'd1;
        end
    end

    // data move request holding register
    assign xreq_ready_o = !xreq_pend && !sys_reset_o;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            xreq_pend <= 1'b0;
            xreq_q    <= '0;
        end else if (sys_reset_o) begin
            xreq_pend <= 1'b0;
        end else if (xreq_valid_i && xreq_ready_o) begin
            xreq_pend <= 1'b1;
            xreq_q    <= xreq_i;
        end else if (slot == SLOT_XDATA_B && slot_end) begin
            xreq_pend <= 1'b0;
        end
    end

    // slot sequencing: a data move takes a whole machine cycle
    always_comb begin
        next_slot = slot;
        if (slot_end) begin
            unique case (slot)
                SLOT_CODE:    next_slot = (slot_idx && xreq_pend) ? SLOT_XDATA_A : SLOT_CODE;
                SLOT_XDATA_A: next_slot = SLOT_XDATA_B;
                SLOT_XDATA_B: next_slot = SLOT_CODE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            slot <= SLOT_CODE;
        end else if (sys_reset_o) begin
            slot <= SLOT_CODE;
        end else begin
            slot <= next_slot;
        end
    end

    // strobe pattern for the current phase
    assign ale_allowed = fetch_external_i || !auxiliary_control[AUX_ALE_OFF];

    always_comb begin
        next_strb = '{ale: 1'b0, fetch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
        unique case (slot)
            SLOT_CODE: begin
                next_strb.ale     = (phase == 3'd0) ? ale_allowed
                                                    : ale_o && (phase < ale_len);
                next_strb.fetch_n = !(fetch_external_i && phase >= ale_len);
            end
            SLOT_XDATA_A: begin
                next_strb.ale  = (phase < ale_len);
                next_strb.rd_n = xreq_q.write || (phase < ale_len);
                next_strb.wr_n = !xreq_q.write || (phase < ale_len);
            end
            SLOT_XDATA_B: begin
                // no latch pulse and no fetch strobe in this slot
                next_strb.rd_n = xreq_q.write || slot_end;
                next_strb.wr_n = !xreq_q.write || slot_end;
            end
        endcase
        if (sys_reset_o) begin
            next_strb = '{ale: 1'b0, fetch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ale_o                    <= 1'b0;
            program_fetch_strobe_n_o <= 1'b1;
            rd_n_o                   <= 1'b1;
            wr_n_o                   <= 1'b1;
        end else begin
            ale_o                    <= next_strb.ale;
            program_fetch_strobe_n_o <= next_strb.fetch_n;
            rd_n_o                   <= next_strb.rd_n;
            wr_n_o                   <= next_strb.wr_n;
        end
    end

    // address and data drive
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            port0_o             <= 8'hff;
            port0_oe_o          <= 1'b0;
            high_address_port_o <= 8'hff;
        end else if (sys_reset_o) begin
            port0_o             <= 8'hff;
            port0_oe_o          <= 1'b0;
            high_address_port_o <= 8'hff;
        end else begin
            unique case (slot)
                SLOT_CODE: begin
                    high_address_port_o <= fetch_external_i ? fetch_addr_i[15:8]
                                                            : high_address_latch_i;
                    port0_o    <= fetch_addr_i[7:0];
                    port0_oe_o <= fetch_external_i && (phase < ale_len);
                end
                default: begin
                    high_address_port_o <= xreq_q.short_addr ? high_address_latch_i
                                                             : xreq_q.addr[15:8];
                    if (slot == SLOT_XDATA_A && phase < ale_len) begin
                        port0_o    <= xreq_q.addr[7:0];
                        port0_oe_o <= 1'b1;
                    end else begin
                        port0_o    <= xreq_q.wdata;
                        port0_oe_o <= xreq_q.write;
                    end
                end
            endcase
        end
    end

    // capture returned bytes at the trailing edge of the read strobe, one clock before the fetch strobe's
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            fetch_data_o       <= 8'h00;
            fetch_data_valid_o <= 1'b0;
            xdata_rdata_o      <= 8'h00;
            xdata_done_o       <= 1'b0;
        end else begin
            fetch_data_valid_o <= 1'b0;
            xdata_done_o       <= 1'b0;
            if (!sys_reset_o && slot_end && slot == SLOT_CODE && fetch_external_i) begin
                fetch_data_o       <= port0_s;
                fetch_data_valid_o <= 1'b1;
            end
            if (!sys_reset_o && slot_end && slot == SLOT_XDATA_B) begin
                if (!xreq_q.write) begin
                    xdata_rdata_o <= port0_s;
                end
                xdata_done_o <= 1'b1;
            end
        end
    end
endmodule : ebs_strobes
`default_nettype wire

// [ebs_strobes_asserts.sv]
/* Port checker for the strobe block.
   Assumes binding into ebs_strobes by port name. */
`timescale 1ns/100ps
`default_nettype none
module ebs_strobes_asserts
    import ebs_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       fetch_external_i,
    input wire logic       watchdog_reset_i,
    input wire logic       sys_reset_o,
    input wire logic       double_speed_o,
    input wire logic       ale_o,
    input wire logic       program_fetch_strobe_n_o,
    input wire logic       rd_n_o,
    input wire logic       wr_n_o,
    input wire logic       port0_oe_o,
    input wire logic       rst_pin_i,
    input wire logic       rst_pin_o,
    input wire logic       rst_pin_oe_o
);
    logic [5:0] hi_cnt;
    // cycles the pin has been held high from outside
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hi_cnt <= 6'h00;
        end else if (!rst_pin_i || rst_pin_oe_o) begin
            hi_cnt <= 6'h00;
        end else if (hi_cnt != 6'h3f) begin
            hi_cnt <= hi_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    property p_idle;
        sys_reset_o [*3] |-> !ale_o && program_fetch_strobe_n_o && rd_n_o && wr_n_o;
    endproperty
    a_idle: assert property (p_idle) else $error("strobe active in reset");
    property p_rw; rd_n_o || wr_n_o; endproperty
    a_rw: assert property (p_rw) else $error("read and write both low");
    property p_move; !(rd_n_o && wr_n_o) |-> program_fetch_strobe_n_o; endproperty
    a_move: assert property (p_move) else $error("fetch strobe in data move");
    property p_int; (!fetch_external_i) [*8] |-> program_fetch_strobe_n_o; endproperty
    a_int: assert property (p_int) else $error("fetch strobe on internal code");
    property p_ale_std;
        disable iff (reset_i || sys_reset_o) $rose(ale_o) && !double_speed_o |=> ale_o ##1 !ale_o;
    endproperty
    a_ale_std: assert property (p_ale_std) else $error("latch pulse width");
    property p_ale_x2;
        disable iff (reset_i || sys_reset_o) $rose(ale_o) && double_speed_o |=> !ale_o;
    endproperty
    a_ale_x2: assert property (p_ale_x2) else $error("double speed pulse width");
    property p_ale_gap;
        disable iff (reset_i || sys_reset_o)
            $rose(ale_o) && !double_speed_o |=> (!$rose(ale_o)) [*5];
    endproperty
    a_ale_gap: assert property (p_ale_gap) else $error("latch pulses too close");
    property p_wdog; watchdog_reset_i |=> rst_pin_oe_o && rst_pin_o && sys_reset_o; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset not on pin");
    property p_pin; hi_cnt == 6'h20 |-> sys_reset_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset not taken");
    property p_aux; reg_read_i && reg_addr_i == AUX_ADDR |=> (reg_rdata_o & ~AUX_MASK) == 8'h00;
    endproperty
    a_aux: assert property (p_aux) else $error("reserved bits read back");
    property p_wdrv; $fell(wr_n_o) |-> port0_oe_o; endproperty
    a_wdrv: assert property (p_wdrv) else $error("write data not driven");
    c_write: cover property ($fell(wr_n_o));
    c_read: cover property ($fell(rd_n_o));
    c_wdog: cover property ($rose(rst_pin_oe_o));
endmodule : ebs_strobes_asserts
bind ebs_strobes ebs_strobes_asserts chk_u (.*);
`default_nettype wire

// [ebs_sync.sv]
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous to clk_sys_i.
 */
`timescale 1ns/100ps
`default_nettype none
module ebs_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] INIT   = '0
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= INIT;
            sync_o <= INIT;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : ebs_sync
`default_nettype wire

// [ebs_tb.sv]
/* Testbench for the strobe block.
   Assumes ebs_mem_model on the pins and the checker bound in. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ebs_pkg::*;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1, reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic        fetch_external_i = 1'b0, xreq_valid_i = 1'b0, watchdog_reset_i = 1'b0;
    logic        security_level1_i = 1'b0, external_code_select_i = 1'b0, rst_drv = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, high_address_latch_i = 8'h77;
    logic [15:0] fetch_addr_i = 16'h12c3, last_addr;
    ebs_xreq_t   xreq_i = '0;
    logic [7:0]  reg_rdata_o, fetch_data_o, xdata_rdata_o, high_address_port_o, port0_i, port0_o;
    logic        fetch_data_valid_o, xreq_ready_o, xdata_done_o, sys_reset_o, code_external_o;
    logic        double_speed_o, ale_o, program_fetch_strobe_n_o, rd_n_o, wr_n_o, port0_oe_o;
    logic        rst_pin_o, rst_pin_oe_o, cnt_en = 1'b0, fet_chk = 1'b0;
    logic [3:0]  prev = 4'h0;
    int          bad_count = 0, num_checks = 0, cyc = 0, n_ale, n_fet, n_rd, n_wr;
    wire logic   rst_pin_i = rst_pin_oe_o ? rst_pin_o : rst_drv;
    ebs_strobes dut_u (.*);
    ebs_mem_model mem_u (.clk_sys_i(clk_sys_i), .ale_i(ale_o),
        .fetch_n_i(program_fetch_strobe_n_o),
        .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .high_i(high_address_port_o), .bus_i(port0_o),
        .bus_oe_i(port0_oe_o), .bus_o(port0_i), .last_addr_o(last_addr));
    always #50 clk_sys_i = ~clk_sys_i;
    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // edge counters over a window, plus the hang limit
    always @(posedge clk_sys_i) begin
        prev <= {ale_o, program_fetch_strobe_n_o, rd_n_o, wr_n_o};
        if (cnt_en) begin
            n_ale += int'(ale_o && !prev[3]);
            n_fet += int'(!program_fetch_strobe_n_o && prev[2]);
            n_rd += int'(!rd_n_o && prev[1]);
            n_wr += int'(!wr_n_o && prev[0]);
        end
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end
    always @(negedge clk_sys_i) begin
        if (fet_chk && fetch_data_valid_o) check(16'(fetch_data_o), 16'h008b);
    end
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_read_i <= 1'b0;
        @(negedge clk_sys_i);
        check(16'(reg_rdata_o), 16'(e));
        @(posedge clk_sys_i);
    endtask : reg_chk
    task automatic window(input int n);
        n_ale = 0;
        n_fet = 0;
        n_rd = 0;
        n_wr = 0;
        cnt_en <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        cnt_en <= 1'b0;
        @(posedge clk_sys_i);
    endtask : window
    task automatic move(input logic w, input logic sh, input logic [7:0] d);
        int k;
        fork
            window(120);
            begin
                xreq_i <= {16'h3a15, d, w, sh};
                xreq_valid_i <= 1'b1;
                @(posedge clk_sys_i);
                xreq_valid_i <= 1'b0;
                @(negedge clk_sys_i);
                check(16'(xreq_ready_o), 16'h0000);
                for (k = 0; k < 100 && xdata_done_o !== 1'b1; k++) @(negedge clk_sys_i);
                check(16'(xdata_done_o), 16'h0001);
                if (!w) check(16'(xdata_rdata_o), 16'(d));
            end
        join
    endtask : move
    initial begin
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        reg_chk(AUX_ADDR, AUX_RESET);
        reg_chk(CLK_ADDR, CLK_RESET);
        reg_wr(AUX_ADDR, 8'hff);
        reg_chk(AUX_ADDR, AUX_MASK);
        reg_wr(8'h8d, 8'hff);
        reg_chk(8'h8d, 8'h00);
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            reg_wr(CLK_ADDR, m[0] ? 8'hff : 8'h00);
            reg_wr(AUX_ADDR, 8'h00);
            repeat (24) @(posedge clk_sys_i);
            reg_chk(CLK_ADDR, m[0] ? CLK_MASK : CLK_RESET);
            window(120);
            check(16'(n_ale), m[0] ? 16'h0028 : 16'h0014);
            check(16'(n_fet), 16'h0000);
            reg_wr(AUX_ADDR, 8'h01);
            repeat (24) @(posedge clk_sys_i);
            window(120);
            check(16'(n_ale), 16'h0000);
        end
        reg_wr(CLK_ADDR, 8'h00);
        $display("test latch strobe rate done");
        external_code_select_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check(16'(code_external_o), 16'h0000);
        external_code_select_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        check(16'(code_external_o), 16'h0001);
        fetch_external_i <= 1'b1;
        repeat (24) @(posedge clk_sys_i);
        fet_chk <= 1'b1;
        window(120);
        fet_chk <= 1'b0;
        check(16'(n_fet), 16'h0014);
        check(16'(n_ale), 16'h0014);
        $display("test external fetch done");
        for (int i = 0; i < 4; i++) begin
            move(!i[0], i[1], {7'h50, i[1]});
            check(last_addr, i[1] ? {high_address_latch_i, 8'h15} : 16'h3a15);
            check(16'(n_wr), 16'(!i[0]));
            check(16'(n_rd), 16'(i[0]));
            check(16'(n_ale), 16'h0013);
            check(16'(n_fet), 16'h0012);
        end
        $display("test data moves done");
        watchdog_reset_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check(16'(rst_pin_oe_o & rst_pin_o & sys_reset_o), 16'h0001);
        watchdog_reset_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        reg_chk(AUX_ADDR, AUX_RESET);
        reg_wr(AUX_ADDR, 8'h01);
        rst_drv <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_drv <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        reg_chk(AUX_ADDR, 8'h01);
        security_level1_i <= 1'b1;
        rst_drv <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        check(16'(sys_reset_o), 16'h0001);
        rst_drv <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        reg_chk(AUX_ADDR, AUX_RESET);
        external_code_select_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check(16'(code_external_o), 16'h0001);
        $display("test resets done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
